// >>> hdl/sbc_fault_wake_status_bank.sv
// Functional notes
// (R1) Severe overtemp sets bit 2 and forces fail-safe mode.
// (R2) First-level shutdown sets bit 1, prewarning sets bit 0.
// (R3) Thermal flags stay set until the host clears them.
// (R4) Prior state reads 01 after failure or fail-safe wake, 10 after sleep.
// (R5) Sleep from stop or with no wake source counts as failure.
// (R6) Sleep attempt with wake flags set records the sleep code.
// (R7) Watchdog fail count reaches 01 in config 2, 10 otherwise, never 11.
// (R8) Device clears fail count on good trigger or a watchdog stop not caused by a watchdog failure.
// (R9) In configs 2 and 4 the count freezes until a good trigger.
// (R10) Config 0: first watchdog failure only forces restart, no fail output.
// (R11) Invalid serial command sets bad command flag, only host clears it.
// (R12) Fail output activation sets the fail output flag.
// (R13) Transceiver fault code: 00 none, 01 TSD, 10 TXD, 11 bus dominant.
// (R14) Bus undervoltage sets bit 0, disables transmitter, only when mode bit 1.
// (R15) TXD timeout ends on TXD high or transmitter wake-capable/off.
// (R16) Bus dominant timeout ends on recessive bus or transceiver wake/off.
// (R17) After a fault TXD must stay high for enable time before transmit.
// (R18) Bus timeout flag sets on bus silence only with selective wake on.
// (R19) Bus timeout raises interrupt in stop/normal mode when masked in.
// (R20) Clears of bus timeout are ignored until next interrupt falling edge.
// (R21) Selective wake error on config error or counter above 32.
// (R22) Wake flags: bus 5, timer 4, inputs 2..0, also on fail-safe wake.
// (R23) Host reads with command bit 7 low, clears with it high.
// (R24) A cleared flag sets again on the next detection of its cause.
module sbc_fault_wake_status_bank
  import status_bank_pkg::*;
#(
  parameter int DOM_CYCLES = DOM_TIMEOUT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       cmd_invalid,
  input  wire logic       severe_ot_det,
  input  wire logic       first_ot_det,
  input  wire logic       prewarn_det,
  input  wire logic       restart_failure,
  input  wire logic       failsafe_wake,
  input  wire logic       sleep_restart,
  input  wire logic       sleep_req,
  input  wire logic       in_stop_mode,
  input  wire logic       in_normal_mode,
  input  wire logic       any_wake_enabled,
  input  wire logic [2:0] wd_config,
  input  wire logic       wd_miss_event,
  input  wire logic       wd_trigger_ok,
  input  wire logic       wd_stopped,
  input  wire logic       lowpower_by_wd,
  input  wire logic       trx_tsd_det,
  input  wire logic       txd_in,
  input  wire logic       bus_dominant,
  input  wire logic [1:0] trx_mode,
  input  wire logic       bus_supply_low,
  input  wire logic       selective_wake,
  input  wire logic       bus_silence_flag,
  input  wire logic       bus_timeout_irq_mask,
  input  wire logic       int_pin_n,
  input  wire logic       sel_wake_cfg_err,
  input  wire logic [5:0] proto_err_count,
  input  wire logic       bus_wake_det,
  input  wire logic       timer_wake_det,
  input  wire logic [2:0] input_wake_det,
  output logic [7:0]      rd_data,
  output logic            failsafe_req,
  output logic            restart_req,
  output logic            fail_output_pin,
  output logic            tx_enable,
  output logic            bus_timeout_irq,
  output logic            sel_wake_blocked
);

  logic [2:0] thermal_flags;
  logic [1:0] prior_state_code;
  logic [1:0] watchdog_fail_count;
  logic       bad_cmd_flag;
  logic       fail_output_flag;
  logic       bus_timeout_flag;
  logic       selective_wake_sys_error;
  logic [1:0] bus_fault_code;
  logic       bus_supply_undervolt_flag;
  logic [4:0] wake_flags;
  logic       wd_frozen;
  logic       int_pin_q;
  logic       timeout_armed;
  logic [31:0] txd_dom_cnt;
  logic [31:0] bus_dom_cnt;
  logic [31:0] tx_en_cnt;
  trx_state_t trx_state;

  logic [6:0] cmd_addr;
  logic       clr_cmd;
  logic       rd_cmd;
  logic       trx_active;
  logic       uv_cmp_on;
  logic       txd_to_hit;
  logic       bus_to_hit;
  logic       wdog_alarm;
  logic       int_fall;
  logic       sleep_fault;

  // Command decode
  function automatic logic clr_hit(input logic [6:0] target);
    return clr_cmd && (cmd_addr == target);
  endfunction

  assign cmd_addr    = cmd_byte[6:0];
  assign clr_cmd     = cmd_valid && cmd_byte[CMD_CLEAR_BIT];  // R23
  assign rd_cmd      = cmd_valid && !cmd_byte[CMD_CLEAR_BIT];  // R23
  assign trx_active  = trx_mode[1];  // R15 R16
  assign uv_cmp_on   = trx_mode[1];
  assign int_fall    = int_pin_q && !int_pin_n;
  assign sleep_fault = sleep_req && (in_stop_mode || !any_wake_enabled);
  assign txd_to_hit  = txd_dom_cnt >= 32'(DOM_CYCLES);
  assign bus_to_hit  = bus_dom_cnt >= 32'(DOM_CYCLES);
  assign wdog_alarm  = wd_miss_event && !(wd_config == CFG_ZERO &&
                       watchdog_fail_count == WD_CNT_ZERO);  // R10

  // Thermal flags, set wins over clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      thermal_flags <= RST_THERMAL[2:0];
    end else begin
      if (clr_hit(ADDR_THERMAL)) begin
        thermal_flags <= 3'h0;  // R3
      end
      if (severe_ot_det || first_ot_det || prewarn_det) begin
        thermal_flags <= (clr_hit(ADDR_THERMAL) ? 3'h0 : thermal_flags) |
                         {severe_ot_det, first_ot_det, prewarn_det};  // R1 R2 R24
      end
    end
  end

  // Prior state code
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prior_state_code <= RST_DEVICE[7:6];
    end else if (restart_failure || failsafe_wake || sleep_fault) begin
      prior_state_code <= PRIOR_FAILURE;  // R4 R5
    end else if (sleep_restart || (sleep_req && wake_flags != 5'h00)) begin
      prior_state_code <= PRIOR_SLEEP;  // R4 R6
    end else if (clr_hit(ADDR_DEVICE)) begin
      prior_state_code <= PRIOR_CLEARED;
    end
  end

  // Watchdog failure counter, device-cleared only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_fail_count <= RST_DEVICE[3:2];
      wd_frozen           <= 1'b0;
    end else if (wd_trigger_ok) begin
      watchdog_fail_count <= WD_CNT_ZERO;  // R8
      wd_frozen           <= 1'b0;  // R9
    end else if (wd_stopped && !lowpower_by_wd) begin
      watchdog_fail_count <= WD_CNT_ZERO;  // R8
      wd_frozen           <= 1'b0;
    end else if (wd_miss_event && !wd_frozen) begin
      if (wd_config == CFG_TWO) begin
        watchdog_fail_count <= WD_CNT_ONE;  // R7
      end else if (watchdog_fail_count != WD_CNT_TWO) begin
        watchdog_fail_count <= watchdog_fail_count + 2'h1;  // R7
      end
      wd_frozen <= (wd_config == CFG_TWO) ||
                   (wd_config == CFG_FOUR && watchdog_fail_count == WD_CNT_ONE);  // R9
    end
  end

  // Bad command and fail output flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bad_cmd_flag     <= RST_DEVICE[1];
      fail_output_flag <= RST_DEVICE[0];
    end else begin
      bad_cmd_flag     <= cmd_invalid || (bad_cmd_flag && !clr_hit(ADDR_DEVICE));  // R11
      fail_output_flag <= wdog_alarm || severe_ot_det ||
                          (fail_output_flag && !clr_hit(ADDR_DEVICE));  // R12
    end
  end

  // Fail output pin and mode requests
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fail_output_pin <= 1'b0;
      failsafe_req    <= 1'b0;
      restart_req     <= 1'b0;
    end else begin
      fail_output_pin <= fail_output_pin || wdog_alarm || severe_ot_det;  // R12
      failsafe_req    <= severe_ot_det;  // R1
      restart_req     <= wd_miss_event;  // R10
    end
  end

  // Dominant time-out counters
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txd_dom_cnt <= 32'h0;
      bus_dom_cnt <= 32'h0;
    end else begin
      if (txd_in || !trx_active) begin
        txd_dom_cnt <= 32'h0;  // R15
      end else if (!txd_to_hit) begin
        txd_dom_cnt <= txd_dom_cnt + 32'h1;
      end
      if (!bus_dominant || !trx_active) begin
        bus_dom_cnt <= 32'h0;  // R16
      end else if (!bus_to_hit) begin
        bus_dom_cnt <= bus_dom_cnt + 32'h1;
      end
    end
  end

  // Transmitter enable sequencing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trx_state <= TRX_ACTIVE;
      tx_en_cnt <= 32'h0;
      tx_enable <= 1'b0;
    end else begin
      unique case (trx_state)
        TRX_ACTIVE: begin
          tx_enable <= trx_active && !(uv_cmp_on && bus_supply_low);  // R14
          if (trx_tsd_det || txd_to_hit || bus_to_hit) begin
            trx_state <= TRX_FAULTED;
            tx_enable <= 1'b0;
          end
        end
        TRX_FAULTED: begin
          tx_enable <= 1'b0;
          tx_en_cnt <= 32'h0;
          if (!trx_tsd_det && !txd_to_hit && !bus_to_hit) begin
            trx_state <= TRX_RECOVER;
          end
        end
        TRX_RECOVER: begin
          tx_enable <= 1'b0;
          if (trx_tsd_det || !txd_in) begin
            tx_en_cnt <= 32'h0;  // R17
          end else if (tx_en_cnt >= 32'(TX_ENABLE_CYC - 1)) begin
            trx_state <= TRX_ACTIVE;  // R17
          end else begin
            tx_en_cnt <= tx_en_cnt + 32'h1;
          end
        end
        default: trx_state <= TRX_ACTIVE;
      endcase
    end
  end

  // Bus status flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_fault_code            <= RST_BUS[2:1];
      bus_supply_undervolt_flag <= RST_BUS[0];
      selective_wake_sys_error  <= RST_BUS[3];
    end else begin
      if (trx_tsd_det) begin
        bus_fault_code <= BUS_FAULT_TSD;  // R13
      end else if (bus_to_hit) begin
        bus_fault_code <= BUS_FAULT_BUS;  // R13
      end else if (txd_to_hit) begin
        bus_fault_code <= BUS_FAULT_TXD;  // R13
      end else if (clr_hit(ADDR_BUS)) begin
        bus_fault_code <= BUS_FAULT_NONE;
      end
      bus_supply_undervolt_flag <= (uv_cmp_on && bus_supply_low) ||
        (bus_supply_undervolt_flag && !clr_hit(ADDR_BUS));  // R14 R24
      if (selective_wake) begin
        selective_wake_sys_error <= sel_wake_cfg_err ||
          (proto_err_count > PROTO_ERR_LIMIT) ||
          (selective_wake_sys_error && !clr_hit(ADDR_BUS));  // R21
      end else if (clr_hit(ADDR_BUS)) begin
        selective_wake_sys_error <= 1'b0;
      end
    end
  end

  // Bus timeout flag with clear lockout until interrupt falls
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_timeout_flag <= RST_BUS[4];
      timeout_armed    <= 1'b0;
      int_pin_q        <= 1'b1;
      bus_timeout_irq  <= 1'b0;
    end else begin
      int_pin_q <= int_pin_n;
      if (selective_wake && bus_silence_flag && !bus_timeout_flag) begin
        bus_timeout_flag <= 1'b1;  // R18
        timeout_armed    <= 1'b0;  // R20
        bus_timeout_irq  <= bus_timeout_irq_mask &&
                            (in_stop_mode || in_normal_mode);  // R19
      end else begin
        bus_timeout_irq <= 1'b0;
        if (int_fall) begin
          timeout_armed <= 1'b1;  // R20
        end
        if (clr_hit(ADDR_BUS) && (timeout_armed || int_fall)) begin
          bus_timeout_flag <= 1'b0;  // R20
        end
      end
    end
  end

  // Wake source flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_flags <= {RST_WAKE[5:4], RST_WAKE[2:0]};
    end else begin
      wake_flags <= {bus_wake_det, timer_wake_det, input_wake_det} |
        (clr_hit(ADDR_WAKE) ? 5'h00 : wake_flags);  // R22 R24
    end
  end

  // Read data register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data          <= 8'h00;
      sel_wake_blocked <= 1'b0;
    end else begin
      sel_wake_blocked <= selective_wake_sys_error;  // R21
      if (rd_cmd || clr_cmd) begin
        unique case (cmd_addr)
          ADDR_THERMAL: rd_data <= {5'h00, thermal_flags};
          ADDR_DEVICE:  rd_data <= {prior_state_code, 2'h0, watchdog_fail_count,
                                    bad_cmd_flag, fail_output_flag};
          ADDR_BUS:     rd_data <= {3'h0, bus_timeout_flag, selective_wake_sys_error,
                                    bus_fault_code, bus_supply_undervolt_flag};
          ADDR_WAKE:    rd_data <= {2'h0, wake_flags[4:3], 1'b0, wake_flags[2:0]};
          default:      rd_data <= 8'h00;
        endcase
      end
    end
  end

  // Checks
  AST_SEVERE_FAILSAFE: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R1
    severe_ot_det |=> failsafe_req && thermal_flags[2]) else $error("no failsafe");
  AST_THERMAL_STICKY: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R3
    thermal_flags[1] && !clr_hit(ADDR_THERMAL) |=> thermal_flags[1])
    else $error("thermal flag lost");
  AST_PRIOR_FAIL: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R4
    restart_failure |=> prior_state_code == PRIOR_FAILURE) else $error("prior code lost");
  AST_WD_NEVER_THREE: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R7
    watchdog_fail_count != 2'h3) else $error("wd count 11");
  AST_WD_CLEAR: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R8
    wd_trigger_ok |=> watchdog_fail_count == WD_CNT_ZERO) else $error("wd not cleared");
  AST_CFG0_NO_FAIL_OUT: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R10
    wd_config == CFG_ZERO && watchdog_fail_count == WD_CNT_ZERO && wd_miss_event &&
    !severe_ot_det && !fail_output_flag |=> !fail_output_flag)
    else $error("cfg0 set fail flag");
  AST_BAD_CMD: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R11
    cmd_invalid |=> bad_cmd_flag) else $error("bad cmd not set");
  AST_UV_GATED: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R14
    !bus_supply_undervolt_flag && !uv_cmp_on |=> !bus_supply_undervolt_flag)
    else $error("uv set while comparator off");
  AST_UV_TX_OFF: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R14
    uv_cmp_on && bus_supply_low |=> !tx_enable) else $error("tx on in undervoltage");
  AST_TIMEOUT_SET: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R18
    selective_wake && bus_silence_flag && !bus_timeout_flag |=> bus_timeout_flag)
    else $error("timeout flag not set");
  AST_TIMEOUT_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R20
    bus_timeout_flag && !timeout_armed && !int_fall |=> bus_timeout_flag)
    else $error("timeout cleared early");
  AST_TRX_OFF_END: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R15 R16
    !trx_active |=> txd_dom_cnt == 32'h0 && bus_dom_cnt == 32'h0)
    else $error("dominant timer kept running");
  AST_WAKE_SET: assert property (@(posedge sys_clk) disable iff (!arst_n)  // R22
    bus_wake_det |=> wake_flags[4]) else $error("bus wake lost");

endmodule : sbc_fault_wake_status_bank

// >>> hdl/status_bank_pkg.sv
package status_bank_pkg;
  // Register addresses (7-bit word addresses)
  localparam logic [6:0] ADDR_THERMAL = 7'h42;
  localparam logic [6:0] ADDR_DEVICE  = 7'h43;
  localparam logic [6:0] ADDR_BUS     = 7'h44;
  localparam logic [6:0] ADDR_WAKE    = 7'h46;
  // Reset values
  localparam logic [7:0] RST_THERMAL = 8'h00;
  localparam logic [7:0] RST_DEVICE  = 8'h00;
  localparam logic [7:0] RST_BUS     = 8'h00;
  localparam logic [7:0] RST_WAKE    = 8'h00;
  // Thermal field positions
  localparam int BIT_SEVERE_OT   = 2;
  localparam int BIT_FIRST_OT    = 1;
  localparam int BIT_PREWARN     = 0;
  // Device history field positions
  localparam int BIT_PRIOR_HI    = 7;
  localparam int BIT_PRIOR_LO    = 6;
  localparam int BIT_WDCNT_HI    = 3;
  localparam int BIT_WDCNT_LO    = 2;
  localparam int BIT_BAD_CMD     = 1;
  localparam int BIT_FAIL_OUT    = 0;
  // Bus status field positions
  localparam int BIT_BUS_TIMEOUT = 4;
  localparam int BIT_SEL_WAKE_ERR = 3;
  localparam int BIT_BUS_FAIL_HI = 2;
  localparam int BIT_BUS_FAIL_LO = 1;
  localparam int BIT_BUS_UV      = 0;
  // Wake status field positions
  localparam int BIT_BUS_WAKE    = 5;
  localparam int BIT_TIMER_WAKE  = 4;
  localparam int BIT_IN3_WAKE    = 2;
  localparam int BIT_IN2_WAKE    = 1;
  localparam int BIT_IN1_WAKE    = 0;
  // Prior state codes
  localparam logic [1:0] PRIOR_CLEARED = 2'h0;
  localparam logic [1:0] PRIOR_FAILURE = 2'h1;
  localparam logic [1:0] PRIOR_SLEEP   = 2'h2;
  // Watchdog failure counts
  localparam logic [1:0] WD_CNT_ZERO   = 2'h0;
  localparam logic [1:0] WD_CNT_ONE    = 2'h1;
  localparam logic [1:0] WD_CNT_TWO    = 2'h2;
  // Transceiver fault codes
  localparam logic [1:0] BUS_FAULT_NONE = 2'h0;
  localparam logic [1:0] BUS_FAULT_TSD  = 2'h1;
  localparam logic [1:0] BUS_FAULT_TXD  = 2'h2;
  localparam logic [1:0] BUS_FAULT_BUS  = 2'h3;
  // Dominant timeout and transmitter enable time
  localparam int DOM_TIMEOUT_MS  = 20;
  localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_MS * 125000;
  localparam int TX_ENABLE_NS    = 8000;
  localparam int TX_ENABLE_CYC   = (TX_ENABLE_NS + 7) / 8;
  // Protocol error counter limit
  localparam logic [5:0] PROTO_ERR_LIMIT = 6'h20;
  // Watchdog configurations
  localparam logic [2:0] CFG_ZERO = 3'h0;
  localparam logic [2:0] CFG_ONE  = 3'h1;
  localparam logic [2:0] CFG_TWO  = 3'h2;
  localparam logic [2:0] CFG_FOUR = 3'h4;
  // Serial access mode bit
  localparam int CMD_CLEAR_BIT = 7;
  // Transceiver states
  typedef enum logic [1:0] {
    TRX_ACTIVE  = 2'b00,
    TRX_FAULTED = 2'b01,
    TRX_RECOVER = 2'b10
  } trx_state_t;
endpackage : status_bank_pkg

// >>> bench/host_model.sv
module host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] rd_data,
  output logic            cmd_valid,
  output logic [7:0]      cmd_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: no command, byte lines show a changing pattern
  initial begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h5a;
  end

  // One command byte: raised after a falling edge, held over the taking edge,
  // then read data is taken a cycle later while it still stands
  task automatic xfer(input logic [7:0] b, output logic [7:0] d);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_byte  = b;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_byte  = ~b;
    @(negedge sys_clk);
    d = rd_data;
  endtask
endmodule // host_model

// >>> bench/sbc_fault_wake_status_bank_bench.sv
module sbc_fault_wake_status_bank_bench import status_bank_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DOMC = 50;

  logic       sys_clk = 1'b0, arst_n, cmd_valid, cmd_invalid, severe_ot_det;
  logic       first_ot_det, prewarn_det, restart_failure, failsafe_wake;
  logic       sleep_restart, sleep_req, in_stop_mode, in_normal_mode;
  logic       any_wake_enabled, wd_miss_event, wd_trigger_ok, wd_stopped;
  logic       lowpower_by_wd, trx_tsd_det, txd_in, bus_dominant, bus_supply_low;
  logic       selective_wake, bus_silence_flag, bus_timeout_irq_mask, int_pin_n;
  logic       sel_wake_cfg_err, bus_wake_det, timer_wake_det, failsafe_req;
  logic       restart_req, fail_output_pin, tx_enable, bus_timeout_irq;
  logic       sel_wake_blocked, seen_rs = 1'b0, seen_irq = 1'b0;
  logic [7:0] cmd_byte, rd_data, d;
  logic [2:0] wd_config, input_wake_det;
  logic [1:0] trx_mode;
  logic [5:0] proto_err_count;
  logic [4:0] m;
  logic [6:0] addrs [5] = '{ADDR_THERMAL, ADDR_DEVICE, ADDR_BUS, ADDR_WAKE, 7'h45};
  int         n_fail = 0, n_checks = 0, seed = 32'hd348;

  sbc_fault_wake_status_bank #(.DOM_CYCLES(DOMC)) sbc_fault_wake_status_bank_inst (
    .sys_clk, .arst_n, .cmd_valid, .cmd_byte, .cmd_invalid, .severe_ot_det,
    .first_ot_det, .prewarn_det, .restart_failure, .failsafe_wake, .sleep_restart,
    .sleep_req, .in_stop_mode, .in_normal_mode, .any_wake_enabled, .wd_config,
    .wd_miss_event, .wd_trigger_ok, .wd_stopped, .lowpower_by_wd, .trx_tsd_det,
    .txd_in, .bus_dominant, .trx_mode, .bus_supply_low, .selective_wake,
    .bus_silence_flag, .bus_timeout_irq_mask, .int_pin_n, .sel_wake_cfg_err,
    .proto_err_count, .bus_wake_det, .timer_wake_det, .input_wake_det, .rd_data,
    .failsafe_req, .restart_req, .fail_output_pin, .tx_enable, .bus_timeout_irq,
    .sel_wake_blocked);

  host_model host_model_inst (.sys_clk, .rd_data, .cmd_valid, .cmd_byte);

  // Clock
  always #4 sys_clk = ~sys_clk;

  // Catch one-cycle pulses for later inspection
  always @(posedge sys_clk) begin
    if (restart_req === 1'b1) seen_rs <= 1'b1;
    if (bus_timeout_irq === 1'b1) seen_irq <= 1'b1;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic rd(input logic [6:0] a);
    host_model_inst.xfer({1'b0, a}, d);
  endtask
  task automatic clr(input logic [6:0] a);
    host_model_inst.xfer({1'b1, a}, d);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick(2);
  endtask
  task automatic prior(ref logic s, input logic [1:0] w);
    pulse(s);
    rd(ADDR_DEVICE);
    chk("prior", 8'(d[7:6]), 8'(w));
    clr(ADDR_DEVICE);
  endtask
  function automatic logic [7:0] wake_exp(input logic [4:0] v);
    return {2'h0, v[4:3], 1'h0, v[2:0]};
  endfunction
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    #200us;
    n_fail++;
    final_report();
  end

  // Main sequence
  initial begin
    {arst_n, cmd_invalid, severe_ot_det, first_ot_det, prewarn_det} = '0;
    {restart_failure, failsafe_wake, sleep_restart, sleep_req, in_stop_mode} = '0;
    {wd_miss_event, wd_trigger_ok, wd_stopped, lowpower_by_wd, trx_tsd_det} = '0;
    {bus_dominant, bus_supply_low, selective_wake, bus_silence_flag} = '0;
    {sel_wake_cfg_err, bus_wake_det, timer_wake_det} = '0;
    {in_normal_mode, any_wake_enabled, txd_in, int_pin_n, bus_timeout_irq_mask} = '1;
    {wd_config, input_wake_det, trx_mode, proto_err_count} = '0;
    repeat (5) @(posedge sys_clk);
    tick();
    arst_n = 1'b1;
    foreach (addrs[k]) begin
      rd(addrs[k]);
      chk("reset_value", d, 8'h00);
    end
    // First watchdog failure with config 0: restart only
    pulse(wd_miss_event);
    tick(3);
    chk("cfg0_pin", 8'(fail_output_pin), 8'h00);
    chk("cfg0_restart", 8'(seen_rs), 8'h01);
    rd(ADDR_DEVICE);
    chk("cfg0_flag", d & 8'h01, 8'h00);
    pulse(wd_trigger_ok);
    // Config 2 counts once then freezes, host cannot clear it
    wd_config = CFG_TWO;
    for (int i = 0; i < 2; i++) begin
      pulse(wd_miss_event);
      rd(ADDR_DEVICE);
      chk("cfg2_count", 8'(d[3:2]), 8'h01);
      chk("fail_flag", 8'(d[0]), 8'h01);
    end
    clr(ADDR_DEVICE);
    rd(ADDR_DEVICE);
    chk("count_hostclr", 8'(d[3:2]), 8'h01);
    pulse(wd_trigger_ok);
    rd(ADDR_DEVICE);
    chk("count_trig", 8'(d[3:2]), 8'h00);
    wd_config = CFG_ONE;
    for (int i = 1; i < 3; i++) begin
      pulse(wd_miss_event);
      rd(ADDR_DEVICE);
      chk("cfg1_count", 8'(d[3:2]), 8'(i));
    end
    // Config 4 counts to two, then holds
    pulse(wd_trigger_ok);
    wd_config = CFG_FOUR;
    for (int i = 1; i < 4; i++) begin
      pulse(wd_miss_event);
      rd(ADDR_DEVICE);
      chk("cfg4_count", 8'(d[3:2]), (i > 2) ? 8'h02 : 8'(i));
    end
    // A stop caused by a watchdog failure keeps the count
    {wd_stopped, lowpower_by_wd} = 2'b11;
    tick(2);
    rd(ADDR_DEVICE);
    chk("count_keep", 8'(d[3:2]), 8'h02);
    lowpower_by_wd = 1'b0;
    tick(2);
    rd(ADDR_DEVICE);
    chk("count_stop", 8'(d[3:2]), 8'h00);
    chk("fail_pin", 8'(fail_output_pin), 8'h01);
    wd_stopped = 1'b0;
    clr(ADDR_DEVICE);
    // Prior state codes
    prior(restart_failure, PRIOR_FAILURE);
    prior(sleep_restart, PRIOR_SLEEP);
    prior(failsafe_wake, PRIOR_FAILURE);
    clr(ADDR_WAKE);
    any_wake_enabled = 1'b0;
    prior(sleep_req, PRIOR_FAILURE);
    {any_wake_enabled, in_stop_mode, in_normal_mode} = 3'b110;
    prior(sleep_req, PRIOR_FAILURE);
    {in_stop_mode, in_normal_mode} = 2'b01;
    pulse(bus_wake_det);
    prior(sleep_req, PRIOR_SLEEP);
    clr(ADDR_WAKE);
    // Bad serial command stays until cleared
    pulse(cmd_invalid);
    rd(ADDR_DEVICE);
    rd(ADDR_DEVICE);
    chk("bad_cmd", d & 8'h02, 8'h02);
    clr(ADDR_DEVICE);
    rd(ADDR_DEVICE);
    chk("bad_cmd_clr", d & 8'h02, 8'h00);
    // Random thermal detections, sticky after the cause goes away
    for (int i = 0; i < 8; i++) begin
      m = 5'($random(seed));
      {severe_ot_det, first_ot_det, prewarn_det} = m[2:0];
      tick(3);
      chk("failsafe", 8'(failsafe_req), 8'(m[2]));
      {severe_ot_det, first_ot_det, prewarn_det} = 3'h0;
      tick(3);
      rd(ADDR_THERMAL);
      chk("thermal", d, {5'h0, m[2:0]});
      clr(ADDR_THERMAL);
    end
    prewarn_det = 1'b1;
    clr(ADDR_THERMAL);
    rd(ADDR_THERMAL);
    chk("therm_reset", d, 8'h01);
    prewarn_det = 1'b0;
    clr(ADDR_THERMAL);
    // Transceiver faults and transmitter re-enable
    trx_mode = 2'b10;
    trx_tsd_det = 1'b1;
    tick(3);
    trx_tsd_det = 1'b0;
    rd(ADDR_BUS);
    chk("tsd_code", d & 8'h06, 8'h02);
    tick(TX_ENABLE_CYC - 100);
    chk("tx_early", 8'(tx_enable), 8'h00);
    tick(150);
    chk("tx_back", 8'(tx_enable), 8'h01);
    clr(ADDR_BUS);
    txd_in = 1'b0;
    tick(DOMC + 20);
    rd(ADDR_BUS);
    chk("txd_code", d & 8'h06, 8'h04);
    chk("txd_off", 8'(tx_enable), 8'h00);
    txd_in = 1'b1;
    clr(ADDR_BUS);
    rd(ADDR_BUS);
    chk("txd_end", d & 8'h06, 8'h00);
    bus_dominant = 1'b1;
    tick(DOMC + 20);
    rd(ADDR_BUS);
    chk("dom_code", d & 8'h06, 8'h06);
    trx_mode = 2'b01;
    tick(3);
    clr(ADDR_BUS);
    rd(ADDR_BUS);
    chk("dom_end", d & 8'h06, 8'h00);
    bus_dominant = 1'b0;
    bus_supply_low = 1'b1;
    tick(3);
    rd(ADDR_BUS);
    chk("uv_off", d & 8'h01, 8'h00);
    trx_mode = 2'b10;
    tick(3);
    rd(ADDR_BUS);
    chk("uv_on", d & 8'h01, 8'h01);
    bus_supply_low = 1'b0;
    clr(ADDR_BUS);
    // Bus timeout needs selective wake, clear held off until the int pin falls
    bus_silence_flag = 1'b1;
    tick(3);
    rd(ADDR_BUS);
    chk("to_noswk", d & 8'h10, 8'h00);
    selective_wake = 1'b1;
    tick(3);
    bus_silence_flag = 1'b0;
    chk("to_irq", 8'(seen_irq), 8'h01);
    clr(ADDR_BUS);
    rd(ADDR_BUS);
    chk("to_held", d & 8'h10, 8'h10);
    int_pin_n = 1'b0;
    tick(2);
    int_pin_n = 1'b1;
    clr(ADDR_BUS);
    rd(ADDR_BUS);
    chk("to_clr", d & 8'h10, 8'h00);
    proto_err_count = 6'h20;
    tick(3);
    rd(ADDR_BUS);
    chk("err_32", d & 8'h08, 8'h00);
    proto_err_count = 6'h21;
    tick(3);
    rd(ADDR_BUS);
    chk("err_33", d & 8'h08, 8'h08);
    chk("sel_wake_block", 8'(sel_wake_blocked), 8'h01);
    {proto_err_count, selective_wake} = '0;
    // Random wake sources
    for (int i = 0; i < 8; i++) begin
      m = 5'($random(seed));
      {bus_wake_det, timer_wake_det, input_wake_det} = m;
      tick();
      {bus_wake_det, timer_wake_det, input_wake_det} = '0;
      tick(2);
      rd(ADDR_WAKE);
      chk("wake", d, wake_exp(m));
      clr(ADDR_WAKE);
    end
    final_report();
  end
endmodule // sbc_fault_wake_status_bank_bench
